// ---- hdl/sacc_host.sv ----
`timescale 1ns/100ps
module sacc_host
  import sacc_pkg::*;
#(
  parameter int BITS = RESULT_BITS
) (
  input wire logic clk,
  input wire logic resetn,
  sacc_link_if.host link,
  input wire logic cmd_valid,
  input wire sacc_cmd_t cmd_code,
  output logic cmd_ready,
  input wire logic shutdown_req,
  output logic [BITS-1:0] data_out,
  output logic data_valid,
  output logic ref_ready_out
);

  localparam int TW = 8;
  localparam logic [3:0] EDGES = 4'(CONVERSION_START_EDGES);
  localparam logic [3:0] LAST_BIT = 4'(BITS);

  // dout and ready come from the device side: four flops each
  logic [1:0] sa_reg, sb_reg, sc_reg, st_reg;
  logic [1:0] sa_next, sb_next, sc_next, st_next;

  always_comb begin
    sa_next = {link.reference_ready, link.dout_wire};
    sb_next = sa_reg;
    sc_next = sb_reg;
    st_next = st_reg;
    for (int i = 0; i < 2; i++) begin
      if (sb_reg[i] == sc_reg[i]) begin
        st_next[i] = sc_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sa_reg <= 2'h0;
      sb_reg <= 2'h0;
      sc_reg <= 2'h0;
      st_reg <= 2'h0;
    end else begin
      sa_reg <= sa_next;
      sb_reg <= sb_next;
      sc_reg <= sc_next;
      st_reg <= st_next;
    end
  end

  sacc_hstate_t state_reg, state_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic [3:0] edge_reg, edge_next;
  logic [2:0] pulses_reg, pulses_next;
  logic [BITS-1:0] shift_reg, shift_next;
  logic [BITS-1:0] data_reg, data_next;
  logic dvalid_reg, dvalid_next;
  logic conversion_start_reg, conversion_start_next;
  logic sclk_reg, sclk_next;
  logic pdn_reg, pdn_next;
  logic tick;

  // timer is the divider: tick is the one-cycle enable of each phase
  assign tick = (timer_reg == '0);

  always_comb begin
    state_next = state_reg;
    timer_next = tick ? timer_reg : timer_reg - 1'b1;
    edge_next = edge_reg;
    pulses_next = pulses_reg;
    shift_next = shift_reg;
    data_next = data_reg;
    dvalid_next = 1'b0;
    conversion_start_next = conversion_start_reg;
    sclk_next = sclk_reg;
    pdn_next = ~shutdown_req;
    case (state_reg)
      SACC_H_IDLE: begin
        if (cmd_valid) begin
          case (cmd_code)
            SACC_CMD_CONVERT: begin
              // strobe released well inside the early window
              conversion_start_next = 1'b1;
              timer_next = TW'(CONVERSION_START_HIGH_CYC - 1);
              edge_next = '0;
              state_next = SACC_H_CONVERSION_START_HI;
            end
            SACC_CMD_NAP, SACC_CMD_SLEEP: begin
              // nap also recovers a stuck device
              conversion_start_next = 1'b1;
              pulses_next = (cmd_code == SACC_CMD_NAP) ? 3'(NAP_PULSES) : 3'(SLEEP_PULSES);
              timer_next = TW'(CONVERSION_START_HIGH_CYC - 1);
              state_next = SACC_H_PULSE_HI;
            end
            default: begin
              // wake pulse of a full half period
              sclk_next = 1'b1;
              timer_next = TW'(SCLK_HALF_CYC - 1);
              state_next = SACC_H_WAKE;
            end
          endcase
        end
      end
      SACC_H_CONVERSION_START_HI: begin
        if (tick) begin
          conversion_start_next = 1'b0;
          timer_next = TW'(SETUP_CYC - 1);
          state_next = SACC_H_SETUP;
        end
      end
      SACC_H_SETUP, SACC_H_CLK_LO: begin
        if (tick && state_reg == SACC_H_CLK_LO && edge_reg == EDGES) begin
          data_next = shift_reg;
          dvalid_next = 1'b1;
          timer_next = TW'(GAP_CYC - 1);
          state_next = SACC_H_GAP;
        end else if (tick) begin
          sclk_next = 1'b1;
          edge_next = edge_reg + 1'b1;
          timer_next = TW'(SCLK_HALF_CYC - 1);
          state_next = SACC_H_CLK_HI;
        end
      end
      SACC_H_CLK_HI: begin
        if (tick) begin
          // bit settled long before the falling edge
          if (edge_reg != '0 && edge_reg <= LAST_BIT) begin
            shift_next = {shift_reg[BITS-2:0], st_reg[0]};
          end
          sclk_next = 1'b0;
          timer_next = TW'(SCLK_HALF_CYC - 1);
          state_next = SACC_H_CLK_LO;
        end
      end
      SACC_H_PULSE_HI: begin
        if (tick) begin
          conversion_start_next = 1'b0;
          pulses_next = pulses_reg - 1'b1;
          timer_next = TW'(CONVERSION_START_HIGH_CYC - 1);
          state_next = SACC_H_PULSE_LO;
        end
      end
      SACC_H_PULSE_LO: begin
        if (tick && pulses_reg == '0) begin
          timer_next = TW'(REQ_SPACE_CYC - 1);
          state_next = SACC_H_WAIT;
        end else if (tick) begin
          conversion_start_next = 1'b1;
          timer_next = TW'(CONVERSION_START_HIGH_CYC - 1);
          state_next = SACC_H_PULSE_HI;
        end
      end
      SACC_H_WAKE: begin
        if (tick) begin
          sclk_next = 1'b0;
          timer_next = TW'(NAP_WAKE_CYC - 1);
          state_next = SACC_H_WAIT;
        end
      end
      SACC_H_GAP, SACC_H_WAIT: begin
        if (tick) begin
          state_next = SACC_H_IDLE;
        end
      end
      default: begin
        state_next = SACC_H_IDLE;
        conversion_start_next = 1'b0;
        sclk_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SACC_H_IDLE;
      timer_reg <= '0;
      edge_reg <= '0;
      pulses_reg <= '0;
      shift_reg <= '0;
      data_reg <= '0;
      dvalid_reg <= 1'b0;
      conversion_start_reg <= 1'b0;
      sclk_reg <= 1'b0;
      pdn_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      edge_reg <= edge_next;
      pulses_reg <= pulses_next;
      shift_reg <= shift_next;
      data_reg <= data_next;
      dvalid_reg <= dvalid_next;
      conversion_start_reg <= conversion_start_next;
      sclk_reg <= sclk_next;
      pdn_reg <= pdn_next;
    end
  end

  assign link.conversion_start = conversion_start_reg;
  assign link.sclk = sclk_reg;
  assign link.power_down_request_n = pdn_reg;
  assign cmd_ready = (state_reg == SACC_H_IDLE);
  assign data_out = data_reg;
  assign data_valid = dvalid_reg;
  assign ref_ready_out = st_reg[1];

endmodule

// ---- hdl/sacc_pkg.sv ----
package sacc_pkg;

  // base clock and result width
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESULT_BITS = 12;

  // power-down protocol: strobes counted while the serial clock sits low
  localparam int NAP_PULSES = 2;
  localparam int SLEEP_PULSES = 4;

  // documented times, each in its own unit
  localparam int WAKE_PULSE_NS = 60;
  localparam int CONVERSION_START_PULSE_NS = 50;
  localparam int CONVERSION_START_RELEASE_NS = 120;
  localparam int CONVERSION_START_SETUP_NS = 100;
  localparam int SCLK_MIN_PERIOD_PS = 312500;
  localparam int CONVERSION_START_TIME_NS = 4100;
  localparam int CONVERSION_START_GAP_NS = 550;
  localparam int NAP_WAKE_NS = 350;
  localparam int REQ_SPACE_NS = 50;

  // least times round up, longest times round down
  localparam int WAKE_CYC = (WAKE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONVERSION_START_HIGH_CYC = (CONVERSION_START_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONVERSION_START_RELEASE_CYC = (CONVERSION_START_RELEASE_NS * 1000) / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (CONVERSION_START_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_CYC = (CONVERSION_START_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NAP_WAKE_CYC = (NAP_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REQ_SPACE_CYC = (REQ_SPACE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // clock edges per conversion: one per bit decision plus one to finish
  localparam int CONVERSION_START_EDGES = RESULT_BITS + 1;

  // host command codes
  typedef enum logic [1:0] {
    SACC_CMD_CONVERT = 2'h0,
    SACC_CMD_NAP = 2'h1,
    SACC_CMD_SLEEP = 2'h2,
    SACC_CMD_WAKE = 2'h3
  } sacc_cmd_t;

  // device power and conversion modes
  typedef enum logic [2:0] {
    SACC_M_IDLE = 3'h0,
    SACC_M_CONVERSION_START = 3'h1,
    SACC_M_NAP = 3'h3,
    SACC_M_SLEEP = 3'h2,
    SACC_M_POWER_DOWN_REQUEST_N = 3'h6
  } sacc_mode_t;

  // host sequencer states
  typedef enum logic [3:0] {
    SACC_H_IDLE = 4'h0,
    SACC_H_CONVERSION_START_HI = 4'h1,
    SACC_H_SETUP = 4'h3,
    SACC_H_CLK_HI = 4'h2,
    SACC_H_CLK_LO = 4'h6,
    SACC_H_GAP = 4'h7,
    SACC_H_PULSE_HI = 4'h5,
    SACC_H_PULSE_LO = 4'h4,
    SACC_H_WAKE = 4'hC,
    SACC_H_WAIT = 4'hD
  } sacc_hstate_t;

endpackage

// ---- hdl/sacc_link_if.sv ----
`timescale 1ns/100ps
interface sacc_link_if;
  logic conversion_start;
  logic sclk;
  logic power_down_request_n;
  logic dout;
  logic dout_oe;
  logic reference_ready;
  wire dout_wire;

  // released data pin reads low, as with a weak pull-down on the board
  assign dout_wire = dout_oe ? dout : 1'b0;

  modport device (
    input conversion_start,
    input sclk,
    input power_down_request_n,
    output dout,
    output dout_oe,
    output reference_ready
  );

  modport host (
    output conversion_start,
    output sclk,
    output power_down_request_n,
    input dout_wire,
    input reference_ready
  );
endinterface

// ---- hdl/sacc_device.sv ----
`timescale 1ns/100ps
module sacc_device
  import sacc_pkg::*;
#(
  parameter int BITS = RESULT_BITS
) (
  input wire logic clk,
  input wire logic resetn,
  sacc_link_if.device link,
  input wire logic [BITS-1:0] analog_code,
  output logic [BITS-1:0] result,
  output logic result_valid,
  output logic busy,
  output sacc_mode_t power_mode
);

  localparam int SY = 3;
  localparam int HC_W = $clog2(WAKE_CYC + 1);
  localparam logic [HC_W-1:0] WAKE_CNT = HC_W'(WAKE_CYC);
  localparam logic [HC_W-1:0] HC_FIRST = HC_W'(1);
  localparam logic [2:0] NAP_CNT = 3'(NAP_PULSES);
  localparam logic [2:0] SLEEP_CNT = 3'(SLEEP_PULSES);
  localparam logic [BITS-1:0] MSB_MASK = {1'b1, {(BITS-1){1'b0}}};

  // input index: 0 strobe, 1 serial clock, 2 shutdown
  logic [SY-1:0] sync_a_reg, sync_a_next;
  logic [SY-1:0] sync_b_reg, sync_b_next;
  logic [SY-1:0] sync_c_reg, sync_c_next;
  logic [SY-1:0] stable_reg, stable_next;

  // pins are asynchronous to clk; a change counts once b and c agree
  always_comb begin
    sync_a_next = {link.power_down_request_n, link.sclk, link.conversion_start};
    sync_b_next = sync_a_reg;
    sync_c_next = sync_b_reg;
    stable_next = stable_reg;
    for (int i = 0; i < SY; i++) begin
      if (sync_b_reg[i] == sync_c_reg[i]) begin
        stable_next[i] = sync_c_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_a_reg <= 3'h4;
      sync_b_reg <= 3'h4;
      sync_c_reg <= 3'h4;
      stable_reg <= 3'h4; // shutdown released, clock and strobe low
    end else begin
      sync_a_reg <= sync_a_next;
      sync_b_reg <= sync_b_next;
      sync_c_reg <= sync_c_next;
      stable_reg <= stable_next;
    end
  end

  logic conversion_start_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic power_down_request_n_active;

  // edges of the filtered pin levels, and the filtered shutdown level
  assign conversion_start_rise = stable_next[0] & ~stable_reg[0];
  assign sclk_rise = stable_next[1] & ~stable_reg[1];
  assign sclk_fall = ~stable_next[1] & stable_reg[1];
  assign power_down_request_n_active = ~stable_reg[2];

  sacc_mode_t mode_reg, mode_next;
  logic [HC_W-1:0] high_cnt_reg, high_cnt_next;
  logic [2:0] pulse_cnt_reg, pulse_cnt_next;
  logic [BITS-1:0] hold_reg, hold_next;
  logic [BITS-1:0] successive_approx_register_reg, successive_approx_register_next;
  logic [BITS-1:0] mask_reg, mask_next;
  logic [BITS-1:0] trial;
  logic [BITS-1:0] result_reg, result_next;
  logic valid_reg, valid_next;
  logic dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic ref_rdy_reg, ref_rdy_next;
  logic wake_ok;

  // mode, conversion and power-down sequencing
  always_comb begin
    mode_next = mode_reg;
    high_cnt_next = high_cnt_reg;
    pulse_cnt_next = pulse_cnt_reg;
    hold_next = hold_reg;
    successive_approx_register_next = successive_approx_register_reg;
    mask_next = mask_reg;
    result_next = result_reg;
    valid_next = 1'b0;
    dout_next = dout_reg;
    oe_next = oe_reg;
    trial = successive_approx_register_reg | mask_reg;

    // clock high time, saturating; starts at one so an exact minimum pulse still wakes
    if (sclk_rise) begin
      high_cnt_next = HC_FIRST;
    end else if (stable_reg[1] && high_cnt_reg != WAKE_CNT) begin
      high_cnt_next = high_cnt_reg + 1'b1;
    end
    wake_ok = sclk_fall && (high_cnt_reg == WAKE_CNT);

    if (sclk_rise) begin
      pulse_cnt_next = '0;
    end else if (conversion_start_rise && !stable_reg[1] && pulse_cnt_reg != SLEEP_CNT) begin
      pulse_cnt_next = pulse_cnt_reg + 1'b1;
    end

    if (power_down_request_n_active) begin
      mode_next = SACC_M_POWER_DOWN_REQUEST_N;
      oe_next = 1'b0;
      pulse_cnt_next = '0;
      mask_next = '0;
    end else begin
      case (mode_reg)
        SACC_M_POWER_DOWN_REQUEST_N: begin
          mode_next = SACC_M_IDLE;
        end
        SACC_M_IDLE: begin
          if (conversion_start_rise) begin
            mode_next = SACC_M_CONVERSION_START;
            hold_next = analog_code;
            successive_approx_register_next = '0;
            mask_next = MSB_MASK;
          end
        end
        SACC_M_CONVERSION_START: begin
          if (conversion_start_rise && pulse_cnt_next == NAP_CNT) begin
            // second strobe with clock low naps
            mode_next = SACC_M_NAP;
            oe_next = 1'b0;
            mask_next = '0;
          end else if (sclk_rise) begin
            if (mask_reg == '0) begin
              mode_next = SACC_M_IDLE;
              oe_next = 1'b0;
              result_next = successive_approx_register_reg;
              valid_next = 1'b1;
            end else begin
              // one decided bit per clock rise
              oe_next = 1'b1;
              dout_next = (trial <= hold_reg);
              if (trial <= hold_reg) begin
                successive_approx_register_next = trial;
              end
              mask_next = mask_reg >> 1;
            end
          end
        end
        SACC_M_NAP: begin
          if (wake_ok) begin
            mode_next = SACC_M_IDLE;
          end else if (conversion_start_rise && pulse_cnt_next == SLEEP_CNT) begin
            mode_next = SACC_M_SLEEP;
          end
        end
        SACC_M_SLEEP: begin
          if (wake_ok) begin
            mode_next = SACC_M_IDLE;
          end
        end
        default: begin
          mode_next = SACC_M_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end

    ref_rdy_next = (mode_next != SACC_M_POWER_DOWN_REQUEST_N);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= SACC_M_IDLE;
      high_cnt_reg <= '0;
      pulse_cnt_reg <= '0;
      hold_reg <= '0;
      successive_approx_register_reg <= '0;
      mask_reg <= '0;
      result_reg <= '0;
      valid_reg <= 1'b0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      ref_rdy_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      high_cnt_reg <= high_cnt_next;
      pulse_cnt_reg <= pulse_cnt_next;
      hold_reg <= hold_next;
      successive_approx_register_reg <= successive_approx_register_next;
      mask_reg <= mask_next;
      result_reg <= result_next;
      valid_reg <= valid_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ref_rdy_reg <= ref_rdy_next;
    end
  end

  // pin and user outputs, all registered except busy decode
  assign link.dout = dout_reg;
  assign link.dout_oe = oe_reg;
  assign link.reference_ready = ref_rdy_reg;
  assign result = result_reg;
  assign result_valid = valid_reg;
  assign busy = (mode_reg == SACC_M_CONVERSION_START);
  assign power_mode = mode_reg;

endmodule

// ---- tb/sacc_link_properties.sv ----
`timescale 1ns/100ps
module sacc_link_properties
  import sacc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic conversion_start,
  input wire logic sclk,
  input wire logic power_down_request_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic reference_ready
);
  logic sclk_d_reg, conversion_start_d_reg, sclk_rise;
  logic [2:0] strobe_cnt_reg, strobe_cnt_next;
  logic [3:0] rise_cnt_reg, rise_cnt_next, since_rise_reg, since_rise_next;

  // raw pin edges; the design filters its pins, so the bounds leave slack
  always_comb begin
    sclk_rise = sclk && !sclk_d_reg;
    strobe_cnt_next = strobe_cnt_reg;
    if (sclk_rise) begin
      strobe_cnt_next = 3'h0;
    end else if (conversion_start && !conversion_start_d_reg && strobe_cnt_reg != 3'h7) begin
      strobe_cnt_next = strobe_cnt_reg + 3'h1;
    end
    rise_cnt_next = dout_oe ? rise_cnt_reg + {3'h0, sclk_rise} : 4'h0;
    since_rise_next = sclk_rise ? 4'h0 : since_rise_reg + {3'h0, since_rise_reg != 4'hF};
  end

  // registers only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d_reg <= 1'b0;
      conversion_start_d_reg <= 1'b0;
      strobe_cnt_reg <= 3'h0;
      rise_cnt_reg <= 4'h0;
      since_rise_reg <= 4'hF;
    end else begin
      sclk_d_reg <= sclk;
      conversion_start_d_reg <= conversion_start;
      strobe_cnt_reg <= strobe_cnt_next;
      rise_cnt_reg <= rise_cnt_next;
      since_rise_reg <= since_rise_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ready_in_shutdown_a: assert property (
    !power_down_request_n [*8] |-> !reference_ready && !dout_oe)
    else $error("ready high or data driven in shutdown");
  ready_when_up_a: assert property (
    power_down_request_n [*8] |-> reference_ready)
    else $error("ready low while powered");
  shift_starts_a: assert property (
    $rose(sclk) && strobe_cnt_reg == 3'h1 && !dout_oe && power_down_request_n |-> ##[2:8] dout_oe)
    else $error("first clock after a strobe did not start shifting");
  nap_no_shift_a: assert property (
    $rose(sclk) && strobe_cnt_reg >= 3'(NAP_PULSES) |-> !dout_oe [*8])
    else $error("data driven by a wake pulse");
  bit_count_a: assert property (
    $fell(dout_oe) && power_down_request_n |-> rise_cnt_reg == 4'(RESULT_BITS))
    else $error("word length wrong");
  dout_settled_a: assert property (
    dout_oe && $changed(dout) |-> since_rise_reg <= 4'h8)
    else $error("data changed away from a clock rise");
  oe_after_clock_a: assert property (
    $rose(dout_oe) |-> since_rise_reg <= 4'h8)
    else $error("data driven without a clock rise");
  // 4.1us is 820 cycles; the first rise trails the strobe by the setup time
  complete_in_time_a: assert property (
    $rose(sclk) && strobe_cnt_reg == 3'h1 && !dout_oe && power_down_request_n |-> ##[1:800] $fell(dout_oe))
    else $error("conversion too slow");

  word_done_c: cover property ($fell(dout_oe) && rise_cnt_reg == 4'hC);
  sleep_wake_c: cover property ($rose(sclk) && strobe_cnt_reg == 3'h4);
  shutdown_c: cover property ($fell(reference_ready));
endmodule

// ---- tb/test_serial_adc_conversion_control.sv ----
`timescale 1ns/100ps
module test_serial_adc_conversion_control;
  import sacc_pkg::*;
  logic clk, resetn, cmd_valid, cmd_ready, shutdown_req, data_valid, ref_ready_out;
  logic busy, busy_b, res_valid, res_valid_b, bit_seen;
  logic [RESULT_BITS-1:0] analog_code, code_b, data_out, result, result_b, word;
  sacc_cmd_t cmd_code;
  sacc_mode_t power_mode, mode_b;
  int n_mismatch, tests_run;
  logic [RESULT_BITS-1:0] codes [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h3A1};
  sacc_cmd_t pd_cmd [2] = '{SACC_CMD_NAP, SACC_CMD_SLEEP};
  sacc_mode_t pd_mode [2] = '{SACC_M_NAP, SACC_M_SLEEP};

  sacc_link_if link_a();
  sacc_link_if link_b();
  sacc_host sacc_host_inst (.clk(clk), .resetn(resetn), .link(link_a.host), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .shutdown_req(shutdown_req), .data_out(data_out),
    .data_valid(data_valid), .ref_ready_out(ref_ready_out));
  sacc_device sacc_device_inst (.clk(clk), .resetn(resetn), .link(link_a.device),
    .analog_code(analog_code), .result(result), .result_valid(res_valid), .busy(busy),
    .power_mode(power_mode));
  // second device faces the bench, which can break host timing on purpose
  sacc_device sacc_device_inst_b (.clk(clk), .resetn(resetn), .link(link_b.device),
    .analog_code(code_b), .result(result_b), .result_valid(res_valid_b), .busy(busy_b),
    .power_mode(mode_b));
  sacc_link_properties sacc_link_properties_inst (.clk(clk), .resetn(resetn),
    .conversion_start(link_a.conversion_start), .sclk(link_a.sclk),
    .power_down_request_n(link_a.power_down_request_n), .dout(link_a.dout),
    .dout_oe(link_a.dout_oe), .reference_ready(link_a.reference_ready));

  // 200 MHz base clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [11:0] x12(input logic b);
    return {11'h000, b};
  endfunction

  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_mode(input sacc_mode_t seen, input sacc_mode_t exp);
    check({9'h000, seen}, {9'h000, exp});
  endtask

  // polled at falling edges so registered outputs have settled
  task automatic wait_high(ref logic s, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: wait timed out", $time);
        summarize();
      end
    end while (s !== 1'b1);
  endtask

  // one host command, held until taken; input moved after latch to prove it is held
  task automatic host_cmd(input sacc_cmd_t code, input logic [RESULT_BITS-1:0] value);
    @(posedge clk);
    analog_code <= value;
    cmd_code <= code;
    cmd_valid <= 1'b1;
    wait_high(cmd_ready, 50);
    @(posedge clk);
    cmd_valid <= 1'b0;
    if (code == SACC_CMD_CONVERT) begin
      wait_high(busy, 40);
      analog_code <= ~value;
      // device pulses its result before the host ends its last low phase
      wait_high(res_valid, 1000);
      check(result, value);
      wait_high(data_valid, 200);
      check(data_out, value);
    end
    wait_high(cmd_ready, 300);
  endtask

  // strobe of 60ns, released before the first decision
  task automatic b_conversion_start();
    @(posedge clk);
    link_b.conversion_start <= 1'b1;
    repeat (12) @(posedge clk);
    link_b.conversion_start <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // one link clock period of 64 cycles; data read at the end of the high phase
  task automatic b_clk(output logic b);
    @(posedge clk);
    link_b.sclk <= 1'b1;
    repeat (31) @(posedge clk);
    b = link_b.dout_wire;
    link_b.sclk <= 1'b0;
    repeat (32) @(posedge clk);
  endtask

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = SACC_CMD_CONVERT;
    shutdown_req = 1'b0;
    analog_code = 12'h000;
    code_b = 12'h6C3;
    link_b.conversion_start = 1'b0;
    link_b.sclk = 1'b0;
    link_b.power_down_request_n = 1'b1;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // ready crosses two filters: device register, then host synchroniser
    repeat (8) @(negedge clk);
    check(x12(ref_ready_out), 12'h001);
    foreach (codes[i]) host_cmd(SACC_CMD_CONVERT, codes[i]);
    // nap then sleep, each woken by a clock pulse
    for (int k = 0; k < 2; k++) begin
      host_cmd(pd_cmd[k], 12'h000);
      repeat (5) @(negedge clk);
      check_mode(power_mode, pd_mode[k]);
      host_cmd(SACC_CMD_WAKE, 12'h000);
      repeat (5) @(negedge clk);
      check_mode(power_mode, SACC_M_IDLE);
      host_cmd(SACC_CMD_CONVERT, 12'h5A6 + 12'(k));
    end
    // shutdown drops ready, release restores it
    @(posedge clk);
    shutdown_req <= 1'b1;
    repeat (14) @(negedge clk);
    check(x12(ref_ready_out), 12'h000);
    check_mode(power_mode, SACC_M_POWER_DOWN_REQUEST_N);
    @(posedge clk);
    shutdown_req <= 1'b0;
    repeat (14) @(negedge clk);
    check(x12(ref_ready_out), 12'h001);
    host_cmd(SACC_CMD_CONVERT, 12'h801);
    // an extra strobe in mid-conversion must not restart it
    b_conversion_start();
    code_b <= 12'h123;
    for (int k = 0; k < 13; k++) begin
      if (k == 4) b_conversion_start();
      b_clk(bit_seen);
      if (k < 12) word[11 - k] = bit_seen;
    end
    check(word, 12'h6C3);
    check(result_b, 12'h6C3);
    check(x12(link_b.dout_oe), 12'h000);
    repeat (110) @(posedge clk);
    // shutdown in mid-conversion stops the second device
    b_conversion_start();
    b_clk(bit_seen);
    @(posedge clk);
    link_b.power_down_request_n <= 1'b0;
    repeat (8) @(negedge clk);
    check(x12(link_b.reference_ready), 12'h000);
    check(x12(link_b.dout_oe), 12'h000);
    check_mode(mode_b, SACC_M_POWER_DOWN_REQUEST_N);
    @(posedge clk);
    link_b.power_down_request_n <= 1'b1;
    repeat (8) @(negedge clk);
    check(x12(link_b.reference_ready), 12'h001);
    summarize();
  end
endmodule
